// >>> bench/tb_checksum_counter_irq_regs.sv
/*
  Self-checking bench for the checksum counter interrupt registers.
  Assumes the map header is on the include path and the design is compiled first.
*/
`timescale 1ns/1ps
`include "ccir_map.svh"

module tb_checksum_counter_irq_regs
  import ccir_pkg::*;
;
  // Bench side of every design port except the protection and strobe inputs, which are tied off
  logic        core_clk;
  logic        resetn;
  logic [27:0] half_evt;
  logic [27:0] full_evt;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  int          failures;
  int          samples_checked;
  logic [31:0] d;
  logic [31:0] e;
  logic [1:0]  r;

  // Device under test; protection is ignored and all strobes are kept on
  ccir_regs uut (
    .CORE_CLK(core_clk), .RESETN(resetn), .HALF_EVT(half_evt), .FULL_EVT(full_evt),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .IRQ(irq)
  );

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // A hung handshake ends the run at once
  task automatic tmo;
    failures++;
    $display("ERROR %0t bus handshake timed out", $time);
    stop_test();
  endtask : tmo

  // Compare tasks, one per kind of result
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t data %h expected %h", $time, g, x);
    end
  endtask : chk_word

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("ERROR %0t response %h expected %h", $time, g, x);
    end
  endtask : chk_resp

  task automatic chk_irq(input logic x);
    samples_checked++;
    if (irq !== x) begin
      failures++;
      $display("ERROR %0t interrupt %b expected %b", $time, irq, x);
    end
  endtask : chk_irq

  // Write: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 50) tmo();
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    // One idle edge so the next request never lands in the same time step
    @(posedge core_clk);
  endtask : axi_write

  // Read: address held until taken, data captured at the valid edge
  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 50) tmo();
    end while (!rvalid);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_read

  // One-cycle counter event pulse
  task automatic pulse(input logic [27:0] h, input logic [27:0] f);
    half_evt <= h;
    full_evt <= f;
    @(posedge core_clk);
    half_evt <= 28'h0000000;
    full_evt <= 28'h0000000;
    @(posedge core_clk);
  endtask : pulse

  // Frame counters sit low, octet counters skip the two reserved bits
  function automatic int bpos(input int n);
    return (n < 14) ? n : n + 2;
  endfunction : bpos

  // Main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    half_evt = 28'h0000000;
    full_evt = 28'h0000000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // Reset values
    axi_read(`CCIR_MASK_OFF, d, r);
    chk_word(d, 32'h00000000);
    chk_resp(r, `CCIR_RESP_OKAY);
    axi_read(`CCIR_STAT_OFF, d, r);
    chk_word(d, 32'h00000000);
    chk_irq(1'b0);
    // Reserved mask bits ignore writes and read zero
    axi_write(`CCIR_MASK_OFF, 32'hFFFFFFFF, r);
    chk_resp(r, `CCIR_RESP_OKAY);
    axi_read(`CCIR_MASK_OFF, d, r);
    chk_word(d, 32'h3FFF3FFF);
    // Every counter: half sets, read clears, maximum sets again, mask blocks both
    for (int n = 0; n < 28; n++) begin
      e = 32'h00000001 << bpos(n);
      axi_write(`CCIR_MASK_OFF, ~e, r);
      pulse(28'h0000001 << n, 28'h0000000);
      chk_irq(1'b1);
      axi_read(`CCIR_STAT_OFF, d, r);
      chk_word(d, e);
      axi_read(`CCIR_STAT_OFF, d, r);
      chk_word(d, 32'h00000000);
      chk_irq(1'b0);
      pulse(28'h0000000, 28'h0000001 << n);
      chk_irq(1'b1);
      axi_write(`CCIR_MASK_OFF, e, r);
      chk_irq(1'b0);
      pulse(28'h0000001 << n, 28'h0000001 << n);
      chk_irq(1'b0);
      axi_read(`CCIR_STAT_OFF, d, r);
      chk_word(d, e);
    end
    // All counters in one cycle land on the implemented bits only
    axi_write(`CCIR_MASK_OFF, 32'h00000000, r);
    pulse(28'hFFFFFFF, 28'h0000000);
    axi_read(`CCIR_STAT_OFF, d, r);
    chk_word(d, 32'h3FFF3FFF);
    // Writing ones clears only the written status bits
    pulse(28'h0000003, 28'h0000000);
    axi_write(`CCIR_STAT_OFF, 32'h00000001, r);
    chk_resp(r, `CCIR_RESP_OKAY);
    chk_irq(1'b1);
    axi_read(`CCIR_STAT_OFF, d, r);
    chk_word(d, 32'h00000002);
    chk_irq(1'b0);
    // Address between the two registers is refused and changes nothing
    axi_write(12'h204, 32'hFFFFFFFF, r);
    chk_resp(r, `CCIR_RESP_SLVERR);
    axi_read(12'h204, d, r);
    chk_resp(r, `CCIR_RESP_SLVERR);
    chk_word(d, 32'h00000000);
    axi_read(`CCIR_MASK_OFF, d, r);
    chk_word(d, 32'h00000000);
    // Reset in mid-run empties both registers and drops the interrupt
    axi_write(`CCIR_MASK_OFF, 32'h0000FFFF, r);
    pulse(28'h0004000, 28'h0000000);
    chk_irq(1'b1);
    resetn <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk_irq(1'b0);
    axi_read(`CCIR_MASK_OFF, d, r);
    chk_word(d, 32'h00000000);
    axi_read(`CCIR_STAT_OFF, d, r);
    chk_word(d, 32'h00000000);
    stop_test();
  end
endmodule : tb_checksum_counter_irq_regs

// >>> design/ccir_map.svh
/*
  Register map, field layout and bus codes of the checksum counter
  interrupt registers.
  Assumes byte addressing on a 32-bit register bus, one word per register.
*/
`ifndef CCIR_MAP_SVH
`define CCIR_MAP_SVH

// Register byte offsets
`define CCIR_MASK_OFF    12'h200
`define CCIR_STAT_OFF    12'h208

// Reset values
`define CCIR_MASK_RST    32'h00000000
`define CCIR_STAT_RST    32'h00000000

// Implemented bits; 31:30 and 15:14 are reserved
`define CCIR_VALID_BITS  32'h3FFF3FFF

// Counter fields: frame counters low, octet counters high
`define CCIR_NUM_CNT     28
`define CCIR_FRM_LSB     0
`define CCIR_FRM_MSB     13
`define CCIR_OCT_LSB     16
`define CCIR_OCT_MSB     29
`define CCIR_CNT_SPLIT   14

// Bus address and response codes
`define CCIR_AW          12
`define CCIR_RESP_OKAY   2'h0
`define CCIR_RESP_SLVERR 2'h2

`endif

// >>> design/ccir_pkg.sv
/*
  Types shared by the checksum counter interrupt register block.
  Assumes the map header supplies every number.
*/
package ccir_pkg;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_MASK,
    SEL_STAT
  } ccir_sel_t;

  // Write channel progress
  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } ccir_wr_st_t;

  // Read channel progress
  typedef enum logic {
    RD_IDLE,
    RD_DATA
  } ccir_rd_st_t;

endpackage : ccir_pkg

// >>> design/ccir_regs.sv
/*
  Checksum counter interrupt mask and status registers on AXI4-Lite.
  Assumes counter half/max events are one-cycle pulses on CORE_CLK.
  The counters and the interrupt merging live elsewhere.
*/
`timescale 1ns/1ps
`include "ccir_map.svh"

// Overview of operation
// - Mask register at 0x200, resets to zero, bits 31:30 and 15:14 read zero.
// - A set mask bit blocks that counter's interrupt at half and at maximum.
// - Mask bits 29..16 are octet counters, ICMP error down to IPv4 good.
// - Mask bits 13..0 are frame counters in the same protocol order.
// - Status register at 0x208, resets to zero, same bit layout as mask.
// - Status bit sets when its counter reaches half and again at maximum.
module ccir_regs
  import ccir_pkg::*;
(
  // Clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESETN,
  // Counter events, bit n is counter n
  input  wire logic [27:0]          HALF_EVT,
  input  wire logic [27:0]          FULL_EVT,
  // Write address channel
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [`CCIR_AW-1:0]  S_AXI_AWADDR,
  input  wire logic [2:0]           S_AXI_AWPROT,
  // Write data channel
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  // Write response channel
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  output logic [1:0]                S_AXI_BRESP,
  // Read address channel
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  input  wire logic [`CCIR_AW-1:0]  S_AXI_ARADDR,
  input  wire logic [2:0]           S_AXI_ARPROT,
  // Read data channel
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  // Interrupt request, level
  output logic                      IRQ
);

  localparam logic [31:0] VALID = `CCIR_VALID_BITS;

  // Address decode, shared by both channels
  function automatic ccir_sel_t ccir_decode(input logic [`CCIR_AW-1:0] a);
    ccir_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && a == `CCIR_MASK_OFF) s = SEL_MASK;
    if (a[1:0] == 2'h0 && a == `CCIR_STAT_OFF) s = SEL_STAT;
    return s;
  endfunction : ccir_decode

  // Place counter events on register bits: frames low, octets high
  function automatic logic [31:0] ccir_spread(input logic [27:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    r[`CCIR_FRM_MSB:`CCIR_FRM_LSB] = v[`CCIR_CNT_SPLIT-1:0];
    r[`CCIR_OCT_MSB:`CCIR_OCT_LSB] = v[`CCIR_NUM_CNT-1:`CCIR_CNT_SPLIT];
    return r;
  endfunction : ccir_spread

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] ccir_bytes(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction : ccir_bytes

  // Write channel storage
  ccir_wr_st_t         wr_st_r;
  ccir_wr_st_t         wr_st_nxt;
  logic                aw_held_r;
  logic                w_held_r;
  logic [`CCIR_AW-1:0] awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic [1:0]          bresp_r;

  // Read channel storage
  ccir_rd_st_t         rd_st_r;
  ccir_rd_st_t         rd_st_nxt;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;

  // Register contents
  logic [31:0]         mask_r;
  logic [31:0]         mask_nxt;
  logic [31:0]         stat_q;
  logic [31:0]         stat_nxt;
  logic                irq_r;

  // Handshake and decode wires
  wire logic           aw_fire;
  wire logic           w_fire;
  wire logic           wr_fire;
  wire logic           ar_fire;
  wire ccir_sel_t      wr_sel;
  wire ccir_sel_t      rd_sel;
  wire logic [31:0]    wr_bits;
  wire logic [31:0]    evt_set;
  wire logic [31:0]    rd_clr;
  wire logic [31:0]    w1c_clr;
  wire logic [31:0]    rd_val;

  // Each channel takes a new item only while nothing is pending on it
  assign S_AXI_AWREADY = !aw_held_r && wr_st_r == WR_COLLECT;
  assign S_AXI_WREADY  = !w_held_r && wr_st_r == WR_COLLECT;
  assign S_AXI_ARREADY = rd_st_r == RD_IDLE;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire  = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  // The write acts once both halves are held, in either order
  assign wr_fire = aw_held_r && w_held_r && wr_st_r == WR_COLLECT;
  assign wr_sel  = ccir_decode(awaddr_r);
  assign rd_sel  = ccir_decode(S_AXI_ARADDR);
  assign wr_bits = ccir_bytes(wstrb_r);

  // Responses and data come straight from flops
  assign S_AXI_BVALID = wr_st_r == WR_RESP;
  assign S_AXI_BRESP  = bresp_r;
  assign S_AXI_RVALID = rd_st_r == RD_DATA;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;
  assign IRQ          = irq_r;

  // Write channel sequencing
  always_comb begin
    wr_st_nxt = wr_st_r;
    case (wr_st_r)
      WR_COLLECT: if (wr_fire) wr_st_nxt = WR_RESP;
      WR_RESP:    if (S_AXI_BREADY) wr_st_nxt = WR_COLLECT;
      default:    wr_st_nxt = WR_COLLECT;
    endcase
  end

  // Address and data are held until the write acts
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      wr_st_r   <= WR_COLLECT;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bresp_r   <= `CCIR_RESP_OKAY;
    end else begin
      wr_st_r   <= wr_st_nxt;
      aw_held_r <= aw_fire || (aw_held_r && !wr_fire);
      w_held_r  <= w_fire || (w_held_r && !wr_fire);
      if (aw_fire) awaddr_r <= S_AXI_AWADDR;
      if (w_fire) begin
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_fire) bresp_r <= wr_sel == SEL_NONE ? `CCIR_RESP_SLVERR : `CCIR_RESP_OKAY;
    end
  end

  // Read channel sequencing
  always_comb begin
    rd_st_nxt = rd_st_r;
    case (rd_st_r)
      RD_IDLE: if (ar_fire) rd_st_nxt = RD_DATA;
      RD_DATA: if (S_AXI_RREADY) rd_st_nxt = RD_IDLE;
      default: rd_st_nxt = RD_IDLE;
    endcase
  end

  // Read value; reserved bits and unmapped words read zero
  assign rd_val = rd_sel == SEL_MASK ? mask_r & VALID :
                  rd_sel == SEL_STAT ? stat_q & VALID :
                  32'h00000000;

  // Read data are captured when the address is taken
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rd_st_r <= RD_IDLE;
      rdata_r <= 32'h00000000;
      rresp_r <= `CCIR_RESP_OKAY;
    end else begin
      rd_st_r <= rd_st_nxt;
      if (ar_fire) begin
        rdata_r <= rd_val;
        rresp_r <= rd_sel == SEL_NONE ? `CCIR_RESP_SLVERR : `CCIR_RESP_OKAY;
      end
    end
  end

  // Mask write honours byte strobes; reserved bits never store
  assign mask_nxt = wr_fire && wr_sel == SEL_MASK ?
                    ((mask_r & ~wr_bits) | (wdata_r & wr_bits)) & VALID :
                    mask_r;

  // Mask register, cleared by reset
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) mask_r <= `CCIR_MASK_RST;
    else         mask_r <= mask_nxt;
  end

  // Half and full events of each counter land on its status bit
  assign evt_set = ccir_spread(HALF_EVT | FULL_EVT);

  // A status read clears every bit it returned
  assign rd_clr  = ar_fire && rd_sel == SEL_STAT ? VALID : 32'h00000000;

  // Writing ones also clears, so drivers can acknowledge without a read
  assign w1c_clr = wr_fire && wr_sel == SEL_STAT ? wdata_r & wr_bits : 32'h00000000;

  // Sticky status bits
  ccir_sticky_bank u_stat (
    .clk      (CORE_CLK),
    .resetn   (RESETN),
    .set_vec  (evt_set),
    .clr_vec  (rd_clr | w1c_clr),
    .stat_q   (stat_q),
    .stat_nxt (stat_nxt)
  );

  // Registered from next values so IRQ tracks status and mask exactly
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) irq_r <= 1'b0;
    else         irq_r <= |(stat_nxt & ~mask_nxt);
  end

  // Checks on the live design
  default clocking ccir_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  // Reserved mask bits stay zero and a full write lands
  a_mask_rsvd_zero: assert property ((mask_r & ~VALID) == 32'h00000000)
    else $error("reserved mask bit set");

  property p_mask_write;
    logic [31:0] v;
    (wr_fire && wr_sel == SEL_MASK && wstrb_r == 4'hF, v = wdata_r)
      |=> mask_r == (v & VALID);
  endproperty
  a_mask_write_lands: assert property (p_mask_write)
    else $error("mask write did not land");

  // Interrupt follows unmasked status
  a_irq_gating: assert property (IRQ == |(stat_q & ~mask_r))
    else $error("interrupt does not match masked status");

  // A masked event alone cannot raise the interrupt
  a_masked_quiet: assert property (
    (stat_q == 32'h00000000 && (evt_set & ~mask_nxt) == 32'h00000000)
      |=> !IRQ)
    else $error("masked event raised interrupt");

  // Octet events go to the high field, frame events to the low
  a_octet_map: assert property (
    HALF_EVT[`CCIR_NUM_CNT-1] |=> stat_q[`CCIR_OCT_MSB])
    else $error("octet event on wrong bit");

  a_frame_map: assert property (
    FULL_EVT[0] |=> stat_q[`CCIR_FRM_LSB])
    else $error("frame event on wrong bit");

  // Reserved status bits never set
  a_stat_rsvd_zero: assert property ((stat_q & ~VALID) == 32'h00000000)
    else $error("reserved status bit set");

  // Every event sets its bit, even during a clearing read
  property p_evt_sets;
    logic [31:0] e;
    (evt_set != 32'h00000000, e = evt_set) |=> (stat_q & e) == e;
  endproperty
  a_event_sets: assert property (p_evt_sets)
    else $error("event lost");

  // A status read returns the bits and then clears them
  a_read_clear: assert property (
    (ar_fire && rd_sel == SEL_STAT && evt_set == 32'h00000000)
      |=> stat_q == 32'h00000000 && S_AXI_RDATA == $past(stat_q))
    else $error("status read did not clear");

  // Write answer comes one cycle after both halves are held
  a_write_answer: assert property (wr_fire |=> S_AXI_BVALID)
    else $error("write response missing");

  // Read data stand until taken
  a_read_hold: assert property (
    (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");

  // Read answer comes one cycle after the address is taken
  a_read_answer: assert property (ar_fire |=> S_AXI_RVALID)
    else $error("read data missing");

  // Write response stands until taken
  a_write_hold: assert property (
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  // Unmapped words answer with an error and change nothing
  a_unmapped_read: assert property (
    (ar_fire && rd_sel == SEL_NONE)
      |=> S_AXI_RRESP == `CCIR_RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");

  a_unmapped_write: assert property (
    (wr_fire && wr_sel == SEL_NONE)
      |=> S_AXI_BRESP == `CCIR_RESP_SLVERR && mask_r == $past(mask_r))
    else $error("unmapped write not refused");

  // Without a clear, a set status bit stays set
  a_status_sticky: assert property (
    (rd_clr | w1c_clr) == 32'h00000000 |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit dropped without a clear");

  // Writing ones clears those status bits when no event competes
  property p_write_clear;
    logic [31:0] c;
    (w1c_clr != 32'h00000000 && evt_set == 32'h00000000, c = w1c_clr)
      |=> (stat_q & c) == 32'h00000000;
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("written ones did not clear status");

  // Reset empties both registers and drops the interrupt
  a_reset_clears: assert property (disable iff (1'b0)
    !RESETN |=> mask_r == `CCIR_MASK_RST && stat_q == `CCIR_STAT_RST && !IRQ)
    else $error("reset left state behind");

  // Main scenarios
  c_irq_raised:   cover property (!IRQ ##1 IRQ);
  c_read_clears:  cover property (ar_fire && rd_sel == SEL_STAT && stat_q != 32'h00000000);
  c_set_on_clear: cover property (rd_clr != 32'h00000000 && evt_set != 32'h00000000);
  c_unmapped:     cover property (S_AXI_BVALID && S_AXI_BRESP == `CCIR_RESP_SLVERR);
  c_mask_blocked: cover property (evt_set != 32'h00000000 && (evt_set & ~mask_nxt) == 32'h00000000);

endmodule : ccir_regs

// >>> design/ccir_sticky_bank.sv
/*
  Bank of sticky status bits: set by hardware events, cleared by software.
  Assumes set and clear vectors come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "ccir_map.svh"

module ccir_sticky_bank
  import ccir_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Set and clear requests
  input  wire logic [31:0] set_vec,
  input  wire logic [31:0] clr_vec,
  // Status
  output logic      [31:0] stat_q,
  output logic      [31:0] stat_nxt
);

  localparam logic [31:0] VALID = `CCIR_VALID_BITS;
  localparam logic [31:0] RSTV  = `CCIR_STAT_RST;

  // Next value per bit; reserved bits never set
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (VALID[i]) begin : g_live
        // Set beats clear so an event in a clearing cycle is kept
        assign stat_nxt[i] = set_vec[i] | (stat_q[i] & ~clr_vec[i]);
      end else begin : g_rsvd
        assign stat_nxt[i] = 1'b0;
      end
    end
  endgenerate

  // One register for the whole word keeps a single driver on the status
  always_ff @(posedge clk) begin
    if (!resetn) stat_q <= RSTV & VALID;
    else         stat_q <= stat_nxt;
  end

endmodule : ccir_sticky_bank
